/* File: shared/pgr_params.svh */
// Register offsets, field positions, reset values and timing counts for the phone gain and driver status bank
`ifndef PGR_PARAMS_SVH
`define PGR_PARAMS_SVH
`define PGR_ADDR_W          8
`define PGR_OFF_GAIN        8'h24
`define PGR_OFF_DRV         8'h25
`define PGR_OFF_IRQ_STAT    8'h30
`define PGR_OFF_IRQ_EN      8'h31
`define PGR_OFF_IRQ_CLR     8'h32
`define PGR_GAIN_WR_MASK    16'h3fff
`define PGR_DRV_WR_MASK     16'h03f0
`define PGR_GAIN_RESET      16'h0000
`define PGR_DRV_CTL_RESET   16'h0000
`define PGR_DRV_DOWN_RESET  6'h3f
`define PGR_NOISE_BIT       14
`define PGR_CLK_MHZ         100
`define PGR_ATTACK_MS0      8
`define PGR_ATTACK_MS1      11
`define PGR_ATTACK_MS2      16
`define PGR_ATTACK_MS3      20
`define PGR_DECAY_MS_MIN    10
`define PGR_DECAY_MS0       100
`define PGR_DECAY_MS1       200
`define PGR_DECAY_MS2       400
`define PGR_DECAY_MS3       500
`define PGR_SEQ_SHORT_MS    802
`define PGR_SEQ_LONG_MS     4006
`endif

/* File: shared/pgr_pkg.sv */
// Types for the phone gain and driver status bank
package pgr_pkg;
	typedef struct packed {
		logic       reserved;
		logic [2:0] noise_threshold;
		logic [1:0] hysteresis;
		logic       clip_stepping;
		logic [2:0] target_level;
		logic [3:0] attack_decay_select;
		logic       loop_enable;
	} pgr_gain_ctl_t;

	typedef struct packed {
		logic       headphone_pop_reduction;
		logic       buzzer_input_route_n;
		logic       speaker_two_to_buzzer_route;
		logic       speaker_one_to_buzzer_route;
		logic       pop_sequence_disable;
		logic       pop_sequence_duration;
	} pgr_drv_ctl_t;

	typedef struct packed {
		logic [2:0] noise_threshold;
		logic [1:0] hysteresis;
		logic       clip_stepping;
		logic [2:0] target_level;
		logic       loop_enable;
		logic [1:0] attack_select;
		logic [2:0] decay_select;
	} pgr_loop_cfg_t;

	typedef enum logic [2:0] {
		PGR_SEQ_IDLE = 3'b001,
		PGR_SEQ_RUN  = 3'b010,
		PGR_SEQ_DONE = 3'b100
	} pgr_seq_state_t;
endpackage : pgr_pkg

/* File: design/pgr_regs.sv */
// Phone gain loop control register and driver power status register with interrupt logic
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "pgr_params.svh"

module pgr_regs #(
	parameter int unsigned SEQ_SHORT_CYCLES = `PGR_SEQ_SHORT_MS * 1000 * `PGR_CLK_MHZ,
	parameter int unsigned SEQ_LONG_CYCLES  = `PGR_SEQ_LONG_MS * 1000 * `PGR_CLK_MHZ
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_n,
	input  wire logic [`PGR_ADDR_W-1:0] i_addr,
	input  wire logic [15:0]            i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [15:0]            o_rdata,
	input  wire logic                   i_phone_below_noise,
	input  wire logic [5:0]             i_driver_down,
	input  wire logic                   i_short_detected,
	input  wire logic                   i_speaker_cap_mode,
	input  wire logic                   i_seq_start,
	output pgr_pkg::pgr_loop_cfg_t      o_loop_cfg,
	output pgr_pkg::pgr_drv_ctl_t       o_drv_ctl,
	output logic                        o_seq_active,
	output logic                        o_irq
);
	localparam int unsigned IRQ_W = 3;

	// Two-flop synchronisers for the analog status levels
	logic [8:0] sync1_reg;
	logic [8:0] sync2_reg;
	wire  [8:0] async_in = {i_speaker_cap_mode, i_short_detected, i_driver_down, i_phone_below_noise};
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync1_reg <= 9'h07e;
			sync2_reg <= 9'h07e;
		end
		else
		begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
		end
	end

	wire       below_noise = sync2_reg[0];
	wire [5:0] driver_down = sync2_reg[6:1];
	wire       short_det   = sync2_reg[7];
	wire       cap_mode    = sync2_reg[8];
	logic      seq_start_d_reg;
	logic      seq_req_reg;
	logic      seq_pin_reg;
	logic      seq_sync1_reg;
	logic      seq_sync2_reg;
	wire       seq_go      = seq_req_reg & ~seq_start_d_reg;

	// Address decode
	wire sel_gain = (i_addr == `PGR_OFF_GAIN);
	wire sel_drv  = (i_addr == `PGR_OFF_DRV);
	wire sel_ist  = (i_addr == `PGR_OFF_IRQ_STAT);
	wire sel_ien  = (i_addr == `PGR_OFF_IRQ_EN);
	wire sel_icl  = (i_addr == `PGR_OFF_IRQ_CLR);

	// Control storage
	logic [15:0] gain_reg;
	logic [15:0] drv_ctl_reg;
	wire  [15:0] gain_next = i_wdata & `PGR_GAIN_WR_MASK & ~(16'h1 << `PGR_NOISE_BIT);
	wire  [15:0] drv_next  = i_wdata & `PGR_DRV_WR_MASK;
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			gain_reg    <= `PGR_GAIN_RESET;
			drv_ctl_reg <= `PGR_DRV_CTL_RESET;
		end
		else
		begin
			if (i_wr && sel_gain)
				gain_reg <= gain_next;
			if (i_wr && sel_drv)
				drv_ctl_reg <= drv_next;
		end
	end

	pgr_pkg::pgr_gain_ctl_t gain_f;
	assign gain_f = pgr_pkg::pgr_gain_ctl_t'(gain_reg);

	// Noise flag only meaningful while the loop runs
	wire noise_flag = below_noise & gain_f.loop_enable;

	// Driver flags hold their last value while a short is reported
	logic [5:0] drv_down_reg;
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			drv_down_reg <= `PGR_DRV_DOWN_RESET;
		else if (!short_det)
			drv_down_reg <= driver_down;
	end

	// Pop sequencing timer
	wire        seq_enable = ~drv_ctl_reg[5];
	wire [31:0] seq_len    = (cap_mode && drv_ctl_reg[4]) ? SEQ_LONG_CYCLES : SEQ_SHORT_CYCLES;
	pgr_pkg::pgr_seq_state_t seq_state_reg;
	pgr_pkg::pgr_seq_state_t seq_state_next;
	logic [31:0] seq_cnt_reg;
	logic        seq_done_pulse;
	always_comb
	begin
		seq_state_next = seq_state_reg;
		seq_done_pulse = 1'b0;
		case (seq_state_reg)
			pgr_pkg::PGR_SEQ_IDLE:
				if (seq_go && seq_enable)
					seq_state_next = pgr_pkg::PGR_SEQ_RUN;
			pgr_pkg::PGR_SEQ_RUN:
				if (!seq_enable)
					seq_state_next = pgr_pkg::PGR_SEQ_IDLE;
				else if (seq_cnt_reg >= seq_len - 32'd1)
					seq_state_next = pgr_pkg::PGR_SEQ_DONE;
			pgr_pkg::PGR_SEQ_DONE:
			begin
				seq_done_pulse = 1'b1;
				seq_state_next = pgr_pkg::PGR_SEQ_IDLE;
			end
			default:
				seq_state_next = pgr_pkg::PGR_SEQ_IDLE;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			seq_state_reg   <= pgr_pkg::PGR_SEQ_IDLE;
			seq_cnt_reg     <= 32'h0;
			seq_req_reg     <= 1'b0;
			seq_start_d_reg <= 1'b0;
		end
		else
		begin
			seq_state_reg   <= seq_state_next;
			seq_cnt_reg     <= (seq_state_reg == pgr_pkg::PGR_SEQ_RUN) ? seq_cnt_reg + 32'd1 : 32'h0;
			seq_req_reg     <= seq_pin_reg;
			seq_start_d_reg <= seq_req_reg;
		end
	end

	// Interrupt sources: noise flag rise, any driver flag change, sequencing done
	logic       noise_d_reg;
	wire  [2:0] irq_event = {seq_done_pulse, drv_down_reg != driver_down && !short_det, noise_flag & ~noise_d_reg};
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_en_reg;
	wire  [IRQ_W-1:0] irq_clr = (i_wr && sel_icl) ? i_wdata[IRQ_W-1:0] : '0;
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			noise_d_reg  <= 1'b0;
			irq_stat_reg <= '0;
			irq_en_reg   <= '0;
		end
		else
		begin
			noise_d_reg  <= noise_flag;
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
			if (i_wr && sel_ien)
				irq_en_reg <= i_wdata[IRQ_W-1:0];
		end
	end

	// Read mux
	wire [15:0] gain_rd = {1'b0, noise_flag, gain_reg[13:0]};
	wire [15:0] drv_rd  = {drv_down_reg, drv_ctl_reg[9:4], 4'h0};
	wire [15:0] rd_mux  = sel_gain ? gain_rd :
	                      sel_drv  ? drv_rd :
	                      sel_ist  ? {13'h0, irq_stat_reg} :
	                      sel_ien  ? {13'h0, irq_en_reg} : 16'h0;

	// Decoded loop configuration
	pgr_pkg::pgr_loop_cfg_t cfg_next;
	always_comb
	begin
		cfg_next.noise_threshold = gain_f.noise_threshold;
		cfg_next.hysteresis      = gain_f.hysteresis;
		cfg_next.clip_stepping   = gain_f.clip_stepping;
		cfg_next.target_level    = gain_f.target_level;
		cfg_next.loop_enable     = gain_f.loop_enable;
		cfg_next.attack_select   = gain_f.attack_decay_select[1:0];
		// Decay code 0 is the 10 ms special case, 1..4 map 100..500 ms
		cfg_next.decay_select    = (gain_f.attack_decay_select == 4'h0) ? 3'h0
		                           : {1'b0, gain_f.attack_decay_select[3:2]} + 3'h1;
	end

	pgr_pkg::pgr_drv_ctl_t drv_f;
	assign drv_f = pgr_pkg::pgr_drv_ctl_t'(drv_ctl_reg[9:4]);

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rdata      <= 16'h0;
			o_loop_cfg   <= '0;
			o_drv_ctl    <= '0;
			o_seq_active <= 1'b0;
			o_irq        <= 1'b0;
		end
		else
		begin
			o_rdata      <= i_rd ? rd_mux : 16'h0;
			o_loop_cfg   <= cfg_next;
			o_drv_ctl    <= drv_f;
			o_seq_active <= (seq_state_next == pgr_pkg::PGR_SEQ_RUN);
			o_irq        <= |((irq_stat_reg & ~irq_clr | irq_event) & irq_en_reg);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			seq_pin_reg <= 1'b0;
		else
			seq_pin_reg <= seq_sync2_reg;
	end
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			seq_sync1_reg <= 1'b0;
			seq_sync2_reg <= 1'b0;
		end
		else
		begin
			seq_sync1_reg <= i_seq_start;
			seq_sync2_reg <= seq_sync1_reg;
		end
	end

	// Assertions
	property p_noise_gated;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_rd && sel_gain && !gain_reg[0]) |=> (o_rdata[14] == 1'b0);
	endproperty
	a_noise_gated: assert property (p_noise_gated) else $error("noise flag set while loop off");

	property p_reserved_zero;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_rd && (sel_gain || sel_drv)) |=> (o_rdata[15] == 1'b0 || $past(sel_drv)) && (!$past(sel_drv) || o_rdata[3:0] == 4'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read nonzero");

	property p_ro_ignored;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_wr && sel_gain) |=> (gain_reg[14] == 1'b0 && gain_reg[15] == 1'b0);
	endproperty
	a_ro_ignored: assert property (p_ro_ignored) else $error("read-only bit stored");

	property p_drv_hold;
		@(posedge i_clock) disable iff (!i_rst_n)
		short_det |=> $stable(drv_down_reg);
	endproperty
	a_drv_hold: assert property (p_drv_hold) else $error("driver flags changed during short");

	property p_seq_skip;
		@(posedge i_clock) disable iff (!i_rst_n)
		drv_ctl_reg[5] |=> !o_seq_active;
	endproperty
	a_seq_skip: assert property (p_seq_skip) else $error("sequencing ran while disabled");

	property p_gain_write;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_wr && sel_gain) ##1 1'b1 |=> (o_loop_cfg.loop_enable == $past(i_wdata[0], 2));
	endproperty
	a_gain_write: assert property (p_gain_write) else $error("enable not forwarded");

	property p_drv_route;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_wr && sel_drv) ##1 1'b1 |=> (o_drv_ctl.buzzer_input_route_n == $past(i_wdata[8], 2));
	endproperty
	a_drv_route: assert property (p_drv_route) else $error("buzzer route not forwarded");

	property p_decay_min;
		@(posedge i_clock) disable iff (!i_rst_n)
		(gain_reg[4:1] == 4'h0) |=> (o_loop_cfg.decay_select == 3'h0);
	endproperty
	a_decay_min: assert property (p_decay_min) else $error("short decay not selected");

	property p_irq_off;
		@(posedge i_clock) disable iff (!i_rst_n)
		(irq_en_reg == '0) |=> !o_irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt raised while all sources masked");

	property p_rdata_idle;
		@(posedge i_clock) disable iff (!i_rst_n)
		!i_rd |=> (o_rdata == 16'h0);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data present without read strobe");

	property p_drv_low_zero;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_rd && sel_drv) |=> (o_rdata[3:0] == 4'h0);
	endproperty
	a_drv_low_zero: assert property (p_drv_low_zero) else $error("driver reserved bits nonzero");

	property p_noise_read;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_rd && sel_gain) |=> (o_rdata[14] == $past(noise_flag));
	endproperty
	a_noise_read: assert property (p_noise_read) else $error("noise flag read wrong");

	property p_drv_flags_read;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_rd && sel_drv) |=> (o_rdata[15:10] == $past(drv_down_reg));
	endproperty
	a_drv_flags_read: assert property (p_drv_flags_read) else $error("driver flags read wrong");

	property p_seq_start;
		@(posedge i_clock) disable iff (!i_rst_n)
		(seq_go && seq_enable && seq_state_reg == pgr_pkg::PGR_SEQ_IDLE) |=> o_seq_active;
	endproperty
	a_seq_start: assert property (p_seq_start) else $error("sequencing did not start");

	property p_clip_write;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_wr && sel_gain) ##1 1'b1 |=> (o_loop_cfg.clip_stepping == $past(i_wdata[8], 2));
	endproperty
	a_clip_write: assert property (p_clip_write) else $error("clip stepping not forwarded");

	property p_pop_write;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_wr && sel_drv) ##1 1'b1 |=> (o_drv_ctl.headphone_pop_reduction == $past(i_wdata[9], 2));
	endproperty
	a_pop_write: assert property (p_pop_write) else $error("pop reduction not forwarded");

	property p_spk_route;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_wr && sel_drv) ##1 1'b1 |=> ({o_drv_ctl.speaker_two_to_buzzer_route, o_drv_ctl.speaker_one_to_buzzer_route}
		                                == $past(i_wdata[7:6], 2));
	endproperty
	a_spk_route: assert property (p_spk_route) else $error("speaker route not forwarded");

	property p_set_wins;
		@(posedge i_clock) disable iff (!i_rst_n)
		(|irq_event) |=> ((irq_stat_reg & $past(irq_event)) == $past(irq_event));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("interrupt event lost");

	property p_ro_drv;
		@(posedge i_clock) disable iff (!i_rst_n)
		(i_wr && sel_drv) |=> (drv_ctl_reg[3:0] == 4'h0 && drv_ctl_reg[15:10] == 6'h00);
	endproperty
	a_ro_drv: assert property (p_ro_drv) else $error("driver read-only bits stored");
endmodule : pgr_regs

/* File: verification/pgr_regs_tb.sv */
// Self-checking bench for the phone gain loop and driver power status register bank
`timescale 1ns/1ps
`include "pgr_params.svh"

module pgr_regs_tb;
	localparam int unsigned SHORT_CYC = 20;
	localparam int unsigned LONG_CYC  = 100;
	logic                   i_clock             = 1'b0;
	logic                   i_rst_n             = 1'b0;
	logic [7:0]             i_addr              = 8'h00;
	logic [15:0]            i_wdata             = 16'h0000;
	logic                   i_wr                = 1'b0;
	logic                   i_rd                = 1'b0;
	logic [15:0]            o_rdata;
	logic                   i_phone_below_noise = 1'b0;
	logic [5:0]             i_driver_down       = 6'h3f;
	logic                   i_short_detected    = 1'b0;
	logic                   i_speaker_cap_mode  = 1'b0;
	logic                   i_seq_start         = 1'b0;
	pgr_pkg::pgr_loop_cfg_t o_loop_cfg;
	pgr_pkg::pgr_drv_ctl_t  o_drv_ctl;
	logic                   o_seq_active;
	logic                   o_irq;
	int                     miscompares = 0;
	int                     num_checks  = 0;
	logic [15:0]            rv;
	logic [3:0]             c;
	logic [2:0]             dec;
	logic                   lp_en;
	int                     len;

	always #5 i_clock = ~i_clock;

	pgr_regs #(.SEQ_SHORT_CYCLES(SHORT_CYC), .SEQ_LONG_CYCLES(LONG_CYC)) i_pgr_regs (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_phone_below_noise(i_phone_below_noise),
		.i_driver_down(i_driver_down), .i_short_detected(i_short_detected),
		.i_speaker_cap_mode(i_speaker_cap_mode), .i_seq_start(i_seq_start),
		.o_loop_cfg(o_loop_cfg), .o_drv_ctl(o_drv_ctl), .o_seq_active(o_seq_active), .o_irq(o_irq)
	);

	task automatic conclude;
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : wait_cyc

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd

	// Raise the start level and count how many cycles sequencing stays active
	task automatic seq_len(input bit en, output int n);
		int t;
		t = 0;
		n = 0;
		@(posedge i_clock);
		i_seq_start <= 1'b1;
		while (o_seq_active !== 1'b1 && t < 40)
		begin
			wait_cyc(1);
			t++;
		end
		if (en && t == 40)
		begin
			miscompares++;
			$display("unexpected seq start: expected 1, seen 0");
			conclude();
		end
		while (o_seq_active === 1'b1 && n < 300)
		begin
			wait_cyc(1);
			n++;
		end
		if (n == 300)
		begin
			miscompares++;
			$display("unexpected seq end: expected 0, seen 1");
			conclude();
		end
		@(posedge i_clock);
		i_seq_start <= 1'b0;
		wait_cyc(8);
	endtask : seq_len

	initial
	begin
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		rd(`PGR_OFF_DRV, rv);
		chk("drv reset", 16'hfc00, rv);
		rd(`PGR_OFF_GAIN, rv);
		chk("gain reset", 16'h0000, rv);
		rd(8'h40, rv);
		chk("unmapped", 16'h0000, rv);
		wr(`PGR_OFF_GAIN, 16'h67ff);
		wait_cyc(3);
		rd(`PGR_OFF_GAIN, rv);
		chk("gain ro bits", 16'h27ff, rv);
		chk("cfg all", 16'h4ffc, {1'b0, o_loop_cfg});
		// Every field swept through its codes; the loop stays off for thresholds 5 to 7
		for (int k = 0; k < 16; k++)
		begin
			c     = k[3:0];
			lp_en = (c[2:0] < 3'h5);
			dec   = (c == 4'h0) ? 3'h0 : {1'b0, c[3:2]} + 3'h1;
			wr(`PGR_OFF_GAIN, {2'b00, c[2:0], c[1:0], c[0], c[2:0], c, lp_en});
			wait_cyc(3);
			chk("cfg code", {1'b0, c[2:0], c[1:0], c[0], c[2:0], lp_en, c[1:0], dec}, {1'b0, o_loop_cfg});
			rd(`PGR_OFF_GAIN, rv);
			chk("gain readback", {2'b00, c[2:0], c[1:0], c[0], c[2:0], c, lp_en}, rv);
		end
		wr(`PGR_OFF_GAIN, 16'h27ff);
		i_phone_below_noise <= 1'b1;
		wait_cyc(6);
		rd(`PGR_OFF_GAIN, rv);
		chk("noise flag", 16'h67ff, rv);
		wr(`PGR_OFF_GAIN, 16'h27fe);
		wait_cyc(3);
		rd(`PGR_OFF_GAIN, rv);
		chk("noise flag off", 16'h27fe, rv);
		chk("loop disabled", 16'h0000, {15'h0, o_loop_cfg.loop_enable});
		// Interrupt: noise rise with the loop on, then mask and clear
		i_phone_below_noise <= 1'b0;
		wr(`PGR_OFF_GAIN, 16'h27ff);
		wr(`PGR_OFF_IRQ_EN, 16'h0001);
		wait_cyc(6);
		wr(`PGR_OFF_IRQ_CLR, 16'h0007);
		wait_cyc(3);
		chk("irq idle", 16'h0000, {15'h0, o_irq});
		i_phone_below_noise <= 1'b1;
		wait_cyc(6);
		chk("irq set", 16'h0001, {15'h0, o_irq});
		rd(`PGR_OFF_IRQ_STAT, rv);
		chk("irq stat", 16'h0001, rv & 16'h0001);
		wr(`PGR_OFF_IRQ_EN, 16'h0000);
		wait_cyc(3);
		chk("irq masked", 16'h0000, {15'h0, o_irq});
		wr(`PGR_OFF_IRQ_EN, 16'h0001);
		wait_cyc(3);
		chk("irq unmasked", 16'h0001, {15'h0, o_irq});
		wr(`PGR_OFF_IRQ_CLR, 16'h0001);
		wait_cyc(3);
		chk("irq cleared", 16'h0000, {15'h0, o_irq});
		rd(`PGR_OFF_IRQ_STAT, rv);
		chk("irq stat clr", 16'h0000, rv & 16'h0001);
		// Driver flags follow the drivers, and freeze while a short is reported
		i_driver_down <= 6'h2a;
		wait_cyc(6);
		rd(`PGR_OFF_DRV, rv);
		chk("drv flags", 16'ha800, rv);
		i_short_detected <= 1'b1;
		wait_cyc(6);
		i_driver_down <= 6'h15;
		wait_cyc(6);
		rd(`PGR_OFF_DRV, rv);
		chk("drv frozen", 16'ha800, rv);
		i_short_detected <= 1'b0;
		wait_cyc(6);
		rd(`PGR_OFF_DRV, rv);
		chk("drv live", 16'h5400, rv);
		wr(`PGR_OFF_DRV, 16'hfff0);
		wait_cyc(3);
		rd(`PGR_OFF_DRV, rv);
		chk("drv ro bits", 16'h57f0, rv);
		for (int k = 0; k < 6; k++)
		begin
			wr(`PGR_OFF_DRV, 16'h0010 << k);
			wait_cyc(3);
			chk("drv ctl bit", 16'h0001 << k, {10'h0, o_drv_ctl});
			rd(`PGR_OFF_DRV, rv);
			chk("drv ctl read", 16'h5400 | (16'h0010 << k), rv);
		end
		// Pop sequencing: short, long in capacitor mode, skipped when disabled
		wr(`PGR_OFF_DRV, 16'h0000);
		wait_cyc(3);
		seq_len(1'b1, len);
		chk("seq short", 16'h0001, {15'h0, len >= SHORT_CYC - 1 && len <= SHORT_CYC + 2});
		rd(`PGR_OFF_IRQ_STAT, rv);
		chk("seq done stat", 16'h0004, rv & 16'h0004);
		i_speaker_cap_mode <= 1'b1;
		wr(`PGR_OFF_DRV, 16'h0010);
		wait_cyc(6);
		seq_len(1'b1, len);
		chk("seq long", 16'h0001, {15'h0, len >= LONG_CYC - 1 && len <= LONG_CYC + 2});
		wr(`PGR_OFF_DRV, 16'h0020);
		wait_cyc(3);
		seq_len(1'b0, len);
		chk("seq skipped", 16'h0000, len[15:0]);
		conclude();
	end
endmodule : pgr_regs_tb
